/* File: serial_peer.sv */
`timescale 1ns/1ns
module serial_peer (
  // Clock
  input wire logic aclk,
  // Completed frames toward the block
  output uart_amr_pkg::rx_evt_s rx_evt,
  output logic rx_evt_valid
);
  initial
  begin
    rx_evt = '0;
    rx_evt_valid = 1'b0;
  end

  // Gap lets the peer answer late; between frames the fields carry junk
  task automatic send(input logic [7:0] data, input logic bit9, input logic stop_ok, input int gap);
    repeat (gap) @(posedge aclk);
    rx_evt <= '{data: data, bit9: bit9, stop_ok: stop_ok};
    rx_evt_valid <= 1'b1;
    @(posedge aclk);
    rx_evt_valid <= 1'b0;
    rx_evt <= ~rx_evt;
  endtask
endmodule

/* File: uart_addr_match_baud_select.sv */
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
module uart_addr_match_baud_select #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Timer overflow pulses
  input wire logic timer1_ovf,
  input wire logic timer2_ovf,
  // Receive shifter events
  input wire uart_amr_pkg::rx_evt_s rx_evt,
  input wire logic rx_evt_valid,
  input wire logic rx_m0_done,
  // Transmit shifter events
  input wire logic tx_m0_done,
  input wire logic tx_stop_begin,
  // Status and control to the shifters
  output logic rx_done_flag,
  output logic tx_done_flag,
  output logic framing_error,
  output logic rx_enable,
  output uart_amr_pkg::mode_e mode,
  output logic tx_ninth_bit,
  output logic rx_load,
  output logic tx_bit_tick,
  output logic rx_os_tick
);
  if (ADDR_W < uart_amr_pkg::ADDR_W_MIN)
  begin : g_addr_w_check
    $error("ADDR_W too narrow for the register map");
  end

  function automatic logic at(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return a == ADDR_W'({idx, 2'b00});
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return at(a, uart_amr_pkg::IDX_SERIAL_CONTROL) | at(a, uart_amr_pkg::IDX_ADDRESS_MASK)
      | at(a, uart_amr_pkg::IDX_OWN_ADDRESS) | at(a, uart_amr_pkg::IDX_BRG_RELOAD)
      | at(a, uart_amr_pkg::IDX_BAUD_CTRL) | at(a, uart_amr_pkg::IDX_TIMER2_CTRL)
      | at(a, uart_amr_pkg::IDX_POWER_CTRL);
  endfunction

  // Bus state
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q, wdata_q;
  logic [3:0] wstrb_q;
  logic [ADDR_W-1:0] awaddr_q;
  // Register state
  logic mode_hi_q, mode_lo_q, mp_q, ren_q, tb8_q, rb8_q, ti_q, ri_q, fe_q;
  logic [7:0] own_q, mask_q, brl_q;
  logic [4:0] bc_q;
  logic tx_timer2_select_q, rclk_q, doubler_q, eba_q;
  // Baud state
  logic [2:0] div6_q;
  logic [7:0] gen_cnt_q;
  logic halfg_q, half1_q, half_clk_q;
  logic [3:0] tx_div_q;
  logic tx_bit_tick_q, rx_os_tick_q, rx_load_q;

  // Write path
  logic do_write, wr_lane0, sc_wr, own_wr, mask_wr, brl_wr, bc_wr, t2_wr, pc_wr;
  logic [7:0] wd;
  assign do_write = !awready_q && !wready_q && !bvalid_q;
  assign wr_lane0 = do_write && wstrb_q[0];
  assign wd = wdata_q[7:0];
  assign sc_wr = wr_lane0 && at(awaddr_q, uart_amr_pkg::IDX_SERIAL_CONTROL);
  assign own_wr = wr_lane0 && at(awaddr_q, uart_amr_pkg::IDX_OWN_ADDRESS);
  assign mask_wr = wr_lane0 && at(awaddr_q, uart_amr_pkg::IDX_ADDRESS_MASK);
  assign brl_wr = wr_lane0 && at(awaddr_q, uart_amr_pkg::IDX_BRG_RELOAD);
  assign bc_wr = wr_lane0 && at(awaddr_q, uart_amr_pkg::IDX_BAUD_CTRL);
  assign t2_wr = wr_lane0 && at(awaddr_q, uart_amr_pkg::IDX_TIMER2_CTRL);
  assign pc_wr = wr_lane0 && at(awaddr_q, uart_amr_pkg::IDX_POWER_CTRL);

  // Receive address filter
  uart_amr_pkg::mode_e mode_w;
  logic mp_eff, frame_in, given_hit, bcast_hit, addr_hit, rx_accept, ri_set, ti_set, fe_set;
  logic [7:0] bcast;
  assign mode_w = uart_amr_pkg::mode_e'({mode_hi_q, mode_lo_q});
  assign mp_eff = mp_q && (mode_w != uart_amr_pkg::MODE_SHIFT);
  assign frame_in = rx_evt_valid && ren_q && (mode_w != uart_amr_pkg::MODE_SHIFT);
  assign given_hit = ((rx_evt.data ^ own_q) & mask_q) == 8'h00;
  assign bcast = own_q | mask_q;
  assign bcast_hit = (~rx_evt.data & bcast) == 8'h00;
  assign addr_hit = given_hit || bcast_hit;
  assign rx_accept = frame_in && (!mp_eff
    || (mode_w == uart_amr_pkg::MODE_UART8 ? addr_hit && rx_evt.stop_ok
    : addr_hit && rx_evt.bit9));
  assign ri_set = rx_accept || (rx_m0_done && ren_q && mode_w == uart_amr_pkg::MODE_SHIFT);
  assign ti_set = (mode_w == uart_amr_pkg::MODE_SHIFT) ? tx_m0_done : tx_stop_begin;
  assign fe_set = frame_in && eba_q && !rx_evt.stop_ok;

  // Next values; hardware sets win over a software clear
  logic mode_hi_d, fe_d, rb8_d, ti_d, ri_d;
  assign mode_hi_d = (sc_wr && !eba_q) ? wd[uart_amr_pkg::SC_BIT7] : mode_hi_q;
  assign fe_d = fe_set || ((sc_wr && eba_q) ? wd[uart_amr_pkg::SC_BIT7] : fe_q);
  assign rb8_d = rx_accept ? rx_evt.bit9 : (sc_wr ? wd[uart_amr_pkg::SC_RB8] : rb8_q);
  assign ti_d = ti_set || (sc_wr ? wd[uart_amr_pkg::SC_TI] : ti_q);
  assign ri_d = ri_set || (sc_wr ? wd[uart_amr_pkg::SC_RI] : ri_q);

  // Read path
  logic [7:0] sc_rd, rd_byte;
  assign sc_rd = {eba_q ? fe_q : mode_hi_q, mode_lo_q, mp_q, ren_q, tb8_q, rb8_q, ti_q, ri_q};
  assign rd_byte = at(araddr, uart_amr_pkg::IDX_SERIAL_CONTROL) ? sc_rd
    : at(araddr, uart_amr_pkg::IDX_ADDRESS_MASK) ? mask_q
    : at(araddr, uart_amr_pkg::IDX_OWN_ADDRESS) ? own_q
    : at(araddr, uart_amr_pkg::IDX_BRG_RELOAD) ? brl_q
    : at(araddr, uart_amr_pkg::IDX_BAUD_CTRL) ? {3'h0, bc_q}
    : at(araddr, uart_amr_pkg::IDX_TIMER2_CTRL) ? {2'h0, rclk_q, tx_timer2_select_q, 4'h0}
    : at(araddr, uart_amr_pkg::IDX_POWER_CTRL) ? {doubler_q, eba_q, 6'h00}
    : 8'h00;

  // Baud generation
  logic pre6, gen_tick, gen_run, gen_ovf, gen16, t1_16, m2_16, m0_bit, tx16, rx16;
  logic [7:0] gen_cnt_d;
  assign pre6 = div6_q == uart_amr_pkg::DIV6_LAST;
  assign gen_run = bc_q[uart_amr_pkg::BC_RUN];
  assign gen_tick = bc_q[uart_amr_pkg::BC_SPD] || pre6;
  assign gen_ovf = gen_run && gen_tick && gen_cnt_q == uart_amr_pkg::CNT_TOP;
  assign gen_cnt_d = !gen_run ? brl_q
    : !gen_tick ? gen_cnt_q
    : gen_ovf ? brl_q
    : gen_cnt_q + 8'h01;
  assign gen16 = gen_ovf && (doubler_q || halfg_q);
  assign t1_16 = timer1_ovf && (doubler_q || half1_q);
  assign m2_16 = doubler_q || half_clk_q;
  assign m0_bit = bc_q[uart_amr_pkg::BC_M0SRC] ? gen_ovf : pre6;
  assign tx16 = (mode_w == uart_amr_pkg::MODE_UART9_FIXED) ? m2_16
    : bc_q[uart_amr_pkg::BC_TXGEN] ? gen16
    : tx_timer2_select_q ? timer2_ovf : t1_16;
  assign rx16 = (mode_w == uart_amr_pkg::MODE_UART9_FIXED) ? m2_16
    : bc_q[uart_amr_pkg::BC_RXGEN] ? gen16
    : rclk_q ? timer2_ovf : t1_16;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div6_q <= 3'h0;
      gen_cnt_q <= uart_amr_pkg::BRL_RESET;
      halfg_q <= 1'b0;
      half1_q <= 1'b0;
      half_clk_q <= 1'b0;
      tx_div_q <= 4'h0;
      tx_bit_tick_q <= 1'b0;
      rx_os_tick_q <= 1'b0;
    end
    else
    begin
      div6_q <= pre6 ? 3'h0 : div6_q + 3'h1;
      gen_cnt_q <= gen_cnt_d;
      halfg_q <= halfg_q ^ gen_ovf;
      half1_q <= half1_q ^ timer1_ovf;
      half_clk_q <= !half_clk_q;
      tx_div_q <= tx_div_q + {3'h0, tx16};
      tx_bit_tick_q <= (mode_w == uart_amr_pkg::MODE_SHIFT) ? m0_bit
        : tx16 && tx_div_q == uart_amr_pkg::OVS_LAST;
      rx_os_tick_q <= (mode_w == uart_amr_pkg::MODE_SHIFT) ? m0_bit : rx16;
    end
  end

  // Register file
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {mode_hi_q, mode_lo_q, mp_q, ren_q, tb8_q, rb8_q, ti_q, ri_q} <= uart_amr_pkg::SC_RESET;
      fe_q <= 1'b0;
      own_q <= uart_amr_pkg::OWN_RESET;
      mask_q <= uart_amr_pkg::MASK_RESET;
      brl_q <= uart_amr_pkg::BRL_RESET;
      bc_q <= uart_amr_pkg::BC_RESET;
      tx_timer2_select_q <= 1'b0;
      rclk_q <= 1'b0;
      doubler_q <= 1'b0;
      eba_q <= 1'b0;
      rx_load_q <= 1'b0;
    end
    else
    begin
      mode_hi_q <= mode_hi_d;
      fe_q <= fe_d;
      rb8_q <= rb8_d;
      ti_q <= ti_d;
      ri_q <= ri_d;
      rx_load_q <= ri_set;
      if (sc_wr)
      begin
        mode_lo_q <= wd[uart_amr_pkg::SC_MODE_LO];
        mp_q <= wd[uart_amr_pkg::SC_MP];
        ren_q <= wd[uart_amr_pkg::SC_REN];
        tb8_q <= wd[uart_amr_pkg::SC_TB8];
      end
      if (own_wr)
        own_q <= wd;
      if (mask_wr)
        mask_q <= wd;
      if (brl_wr)
        brl_q <= wd;
      if (bc_wr)
        bc_q <= wd[4:0];
      if (t2_wr)
      begin
        tx_timer2_select_q <= wd[uart_amr_pkg::T2_TX_TIMER2_SELECT];
        rclk_q <= wd[uart_amr_pkg::T2_RCLK];
      end
      if (pc_wr)
      begin
        doubler_q <= wd[uart_amr_pkg::PC_DOUBLER];
        eba_q <= wd[uart_amr_pkg::PC_EBA];
      end
    end
  end

  // AXI4-Lite slave, one write and one read at a time
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= uart_amr_pkg::RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end
    else
    begin
      if (awvalid && awready_q)
      begin
        awaddr_q <= awaddr;
        awready_q <= 1'b0;
      end
      else if (bvalid_q && bready)
        awready_q <= 1'b1;
      if (wvalid && wready_q)
      begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
        wready_q <= 1'b0;
      end
      else if (bvalid_q && bready)
        wready_q <= 1'b1;
      if (do_write)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= mapped(awaddr_q) ? uart_amr_pkg::RESP_OKAY : uart_amr_pkg::RESP_SLVERR;
      end
      else if (bready)
        bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= uart_amr_pkg::RESP_OKAY;
    end
    else if (arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_byte};
      rresp_q <= mapped(araddr) ? uart_amr_pkg::RESP_OKAY : uart_amr_pkg::RESP_SLVERR;
    end
    else if (rvalid_q && rready)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign rx_done_flag = ri_q;
  assign tx_done_flag = ti_q;
  assign framing_error = fe_q;
  assign rx_enable = ren_q;
  assign mode = uart_amr_pkg::mode_e'({mode_hi_q, mode_lo_q});
  assign tx_ninth_bit = tb8_q;
  assign rx_load = rx_load_q;
  assign tx_bit_tick = tx_bit_tick_q;
  assign rx_os_tick = rx_os_tick_q;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_quiet_idle;
    !sc_wr && !ri_q;
  endsequence

  sequence s_miss9;
    frame_in && mp_eff && mode_w != uart_amr_pkg::MODE_UART8 && !(rx_evt.bit9 && addr_hit);
  endsequence

  property p_miss_no_ri;
    s_miss9 and s_quiet_idle |=> !ri_q;
  endproperty
  a_miss_no_ri: assert property (p_miss_no_ri) else $error("rx_done on unmatched frame");

  property p_m1_stop;
    frame_in && mp_eff && mode_w == uart_amr_pkg::MODE_UART8 && !rx_evt.stop_ok && !sc_wr && !ri_q
      |=> !ri_q;
  endproperty
  a_m1_stop: assert property (p_m1_stop) else $error("mode 1 accepted bad stop");

  property p_m0_mp;
    mode_w == uart_amr_pkg::MODE_SHIFT && mp_q && ren_q && rx_m0_done |=> ri_q ##1 (ri_q || $past(sc_wr));
  endproperty
  a_m0_mp: assert property (p_m0_mp) else $error("mode 0 reception blocked by multiproc");

  property p_given;
    frame_in && mp_eff && mode_w == uart_amr_pkg::MODE_UART9_VAR && rx_evt.bit9
      && ((rx_evt.data ^ own_q) & mask_q) == 8'h00 |=> ri_q && rx_load_q;
  endproperty
  a_given: assert property (p_given) else $error("given address missed");

  property p_bcast;
    frame_in && mp_eff && rx_evt.bit9 && mode_w == uart_amr_pkg::MODE_UART9_FIXED
      && (~rx_evt.data & (own_q | mask_q)) == 8'h00 |=> ri_q;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast address missed");

  property p_reset_clear;
    @(posedge aclk) disable iff (1'b0) !aresetn |=> own_q == 8'h00 && mask_q == 8'h00;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("address regs not cleared");

  property p_reload;
    gen_ovf && !brl_wr && brl_q != uart_amr_pkg::CNT_TOP |=> gen_cnt_q == brl_q
      ##1 (gen_cnt_q == $past(gen_cnt_q) + 8'h01 || !$past(gen_tick) || !$past(gen_run));
  endproperty
  a_reload: assert property (p_reload) else $error("generator reload wrong");

  property p_tx_src;
    mode_w != uart_amr_pkg::MODE_SHIFT && mode_w != uart_amr_pkg::MODE_UART9_FIXED
      && !bc_q[uart_amr_pkg::BC_TXGEN] && tx_timer2_select_q && timer2_ovf
      |=> tx_div_q == $past(tx_div_q) + 4'h1;
  endproperty
  a_tx_src: assert property (p_tx_src) else $error("tx source not timer 2");

  property p_fe_sticky;
    fe_q && !(sc_wr && eba_q) |=> fe_q;
  endproperty
  a_fe_sticky: assert property (p_fe_sticky) else $error("framing error lost");

  property p_ren;
    !ren_q && !rx_m0_done && !sc_wr && !ri_q |=> !ri_q;
  endproperty
  a_ren: assert property (p_ren) else $error("reception while disabled");

  property p_ti;
    mode_w != uart_amr_pkg::MODE_SHIFT && tx_stop_begin |=> ti_q;
  endproperty
  a_ti: assert property (p_ti) else $error("tx_done not set");

  property p_rb8;
    rx_accept |=> rb8_q == $past(rx_evt.bit9);
  endproperty
  a_rb8: assert property (p_rb8) else $error("rx ninth bit not captured");
endmodule

/* File: uart_addr_match_baud_select_tb.sv */
`timescale 1ns/1ns
module uart_addr_match_baud_select_tb;
  localparam logic [11:0] A_SC = {2'h0, uart_amr_pkg::IDX_SERIAL_CONTROL, 2'h0};
  localparam logic [11:0] A_PC = {2'h0, uart_amr_pkg::IDX_POWER_CTRL, 2'h0};
  localparam logic [11:0] A_OWN = {2'h0, uart_amr_pkg::IDX_OWN_ADDRESS, 2'h0};
  localparam logic [11:0] A_MASK = {2'h0, uart_amr_pkg::IDX_ADDRESS_MASK, 2'h0};
  localparam logic [11:0] A_T2 = {2'h0, uart_amr_pkg::IDX_TIMER2_CTRL, 2'h0};
  localparam logic [11:0] A_BRL = {2'h0, uart_amr_pkg::IDX_BRG_RELOAD, 2'h0};
  localparam logic [11:0] A_BC = {2'h0, uart_amr_pkg::IDX_BAUD_CTRL, 2'h0};
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic timer1_ovf, timer2_ovf, rx_evt_valid, rx_m0_done, tx_m0_done, tx_stop_begin;
  logic rx_done_flag, tx_done_flag, framing_error, rx_enable, tx_ninth_bit, rx_load, tx_bit_tick, rx_os_tick;
  uart_amr_pkg::rx_evt_s rx_evt;
  uart_amr_pkg::mode_e mode;
  logic [7:0] sc_v;
  int failures, checked, os_cnt, tx_cnt;

  uart_addr_match_baud_select uart_addr_match_baud_select_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf),
    .rx_evt(rx_evt), .rx_evt_valid(rx_evt_valid), .rx_m0_done(rx_m0_done), .tx_m0_done(tx_m0_done),
    .tx_stop_begin(tx_stop_begin), .rx_done_flag(rx_done_flag), .tx_done_flag(tx_done_flag),
    .framing_error(framing_error), .rx_enable(rx_enable), .mode(mode), .tx_ninth_bit(tx_ninth_bit),
    .rx_load(rx_load), .tx_bit_tick(tx_bit_tick), .rx_os_tick(rx_os_tick)
  );

  serial_peer serial_peer_inst (
    .aclk(aclk),
    .rx_evt(rx_evt),
    .rx_evt_valid(rx_evt_valid)
  );

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // Nonblocking keeps the count stable for readers at the same edge
  always @(posedge aclk)
  begin
    if (rx_os_tick === 1'b1)
      os_cnt <= os_cnt + 1;
    if (tx_bit_tick === 1'b1)
      tx_cnt <= tx_cnt + 1;
  end

  task automatic finish_test();
    if (failures == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      failures++;
    end
  endtask

  task automatic bail();
    failures++;
    finish_test();
  endtask

  task automatic axw(input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      n++;
    end while (!(bvalid && bready) && n < 50);
    resp = bresp;
    if (n >= 50)
      bail();
  endtask

  task automatic axr(input logic [11:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      n++;
    end while (!(rvalid && rready) && n < 50);
    rd = rdata;
    resp = rresp;
    if (n >= 50)
      bail();
  endtask

  task automatic set_sc(input logic [7:0] v);
    sc_v = v;
    axw(A_SC, v);
  endtask

  // Clears the receive flag afterwards so each frame is judged alone
  task automatic rx_try(input logic [7:0] d, input logic b9, input logic st, input logic e);
    serial_peer_inst.send(d, b9, st, 1);
    @(posedge aclk);
    check("rx_done_flag", {31'h0, rx_done_flag}, {31'h0, e});
    check("rx_load", {31'h0, rx_load}, {31'h0, e});
    axw(A_SC, sc_v);
  endtask

  task automatic t_reset();
    axr(A_SC);
    check("serial_control", rd, 32'h0);
    axr(A_OWN);
    check("own_address", rd, 32'h0);
    axr(A_MASK);
    check("address_mask", rd, 32'h0);
    axw(A_MASK, 8'ha5);
    axr(A_MASK);
    check("address_mask rw", rd, 32'ha5);
    axw(A_MASK, 8'h00);
    axr(12'h004);
    check("unmapped resp", {30'h0, resp}, {30'h0, uart_amr_pkg::RESP_SLVERR});
    check("unmapped data", rd, 32'h0);
  endtask

  task automatic t_match();
    logic [7:0] dv [6];
    logic ev [6];
    dv = '{8'h55, 8'h57, 8'h12, 8'hff, 8'hfe, 8'hfb};
    ev = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    set_sc(8'hf0);
    check("rx_enable", {31'h0, rx_enable}, 32'h1);
    rx_try(8'h3c, 1'b1, 1'b1, 1'b1);
    axw(A_OWN, 8'h56);
    axw(A_MASK, 8'hfc);
    // Given 0101_01xx, broadcast 1111_111x
    for (int i = 0; i < 6; i++)
      rx_try(dv[i], 1'b1, 1'b1, ev[i]);
    rx_try(8'h55, 1'b0, 1'b1, 1'b0);
    set_sc(8'hb0);
    rx_try(8'hfe, 1'b1, 1'b1, 1'b1);
    set_sc(8'h70);
    rx_try(8'h55, 1'b1, 1'b0, 1'b0);
    rx_try(8'h55, 1'b1, 1'b1, 1'b1);
    set_sc(8'hd0);
    rx_try(8'h12, 1'b0, 1'b1, 1'b1);
    set_sc(8'hc0);
    rx_try(8'h55, 1'b1, 1'b1, 1'b0);
    set_sc(8'h30);
    rx_m0_done <= 1'b1;
    @(posedge aclk);
    rx_m0_done <= 1'b0;
    @(posedge aclk);
    check("mode0 rx_done_flag", {31'h0, rx_done_flag}, 32'h1);
  endtask

  task automatic t_flags();
    set_sc(8'h50);
    tx_stop_begin <= 1'b1;
    @(posedge aclk);
    tx_stop_begin <= 1'b0;
    @(posedge aclk);
    check("tx_done_flag", {31'h0, tx_done_flag}, 32'h1);
    set_sc(8'h10);
    check("tx_done_flag clear", {31'h0, tx_done_flag}, 32'h0);
    tx_m0_done <= 1'b1;
    @(posedge aclk);
    tx_m0_done <= 1'b0;
    @(posedge aclk);
    check("mode0 tx_done_flag", {31'h0, tx_done_flag}, 32'h1);
    set_sc(8'h50);
    axw(A_PC, 8'h40);
    serial_peer_inst.send(8'h11, 1'b1, 1'b0, 0);
    serial_peer_inst.send(8'h22, 1'b1, 1'b1, 3);
    @(posedge aclk);
    check("framing_error sticky", {31'h0, framing_error}, 32'h1);
    axr(A_SC);
    check("bit7 is error", {31'h0, rd[7]}, 32'h1);
    set_sc(8'h50);
    check("framing_error clear", {31'h0, framing_error}, 32'h0);
    axw(A_PC, 8'h00);
  endtask

  task automatic t_modes();
    for (int m = 0; m < 4; m++)
    begin
      set_sc({m[1:0], 6'h08});
      check("mode", {30'h0, mode}, 32'(m));
      check("tx_ninth_bit", {31'h0, tx_ninth_bit}, 32'h1);
    end
  endtask

  // Both timers pulse together; only the selected one may count
  task automatic pulses(input int n, input int e);
    int c0;
    c0 = os_cnt;
    repeat (n)
    begin
      timer1_ovf <= 1'b1;
      timer2_ovf <= 1'b1;
      @(posedge aclk);
      timer1_ovf <= 1'b0;
      timer2_ovf <= 1'b0;
      @(posedge aclk);
    end
    repeat (2) @(posedge aclk);
    check("rx_os_tick count", 32'(os_cnt - c0), 32'(e));
  endtask

  // One settling edge first, so the window holds whole periods of the new source
  task automatic window(input int n, input int e, input int et);
    int c0, t0;
    @(posedge aclk);
    c0 = os_cnt;
    t0 = tx_cnt;
    repeat (n) @(posedge aclk);
    check("rx_os_tick count", 32'(os_cnt - c0), 32'(e));
    check("tx_bit_tick count", 32'(tx_cnt - t0), 32'(et));
  endtask

  task automatic t_baud();
    set_sc(8'h50);
    pulses(20, 10);
    axw(A_T2, 8'h30);
    pulses(20, 20);
    set_sc(8'h90);
    window(64, 32, 2);
    axw(A_PC, 8'h80);
    window(64, 64, 4);
    set_sc(8'h50);
    axw(A_BRL, 8'hfc);
    axw(A_BC, 8'h16);
    window(64, 16, 0);
    axw(A_PC, 8'h00);
    window(64, 8, 0);
    set_sc(8'h10);
    window(60, 10, 10);
    axw(A_BC, 8'h17);
    window(64, 16, 16);
    axw(A_BC, 8'h15);
    window(48, 2, 2);
  endtask

  initial
  begin
    failures = 0;
    checked = 0;
    os_cnt = 0;
    tx_cnt = 0;
    aresetn = 1'b0;
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = 4'h1;
    wvalid = 1'b0;
    bready = 1'b1;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b1;
    timer1_ovf = 1'b0;
    timer2_ovf = 1'b0;
    rx_m0_done = 1'b0;
    tx_m0_done = 1'b0;
    tx_stop_begin = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_match();
    t_flags();
    t_modes();
    t_baud();
    finish_test();
  end
endmodule

/* File: uart_amr_pkg.sv */
// Notes on behaviour
// - Address matching works only while multiproc_enable is set.
// - With matching on, rx_done_flag rises only for frames addressed here.
// - Mode 1 matching uses the stop bit; accept needs a match and valid stop.
// - multiproc_enable has no effect in mode 0; keep it cleared there.
// - Given address compares only bits whose mask bit is one.
// - Broadcast address is own OR mask; its zero bits are don't care.
// - A frame is accepted on a given or a broadcast match.
// - Own address and mask reset to zero, so every address is accepted.
// - Tx and rx clock sources chosen apart: generator, else timer 2, else timer 1.
// - Generator baud timing follows reload value, speed select and doubler.
// - Generator rate is 2^doubler*fclk / (2*6^(1-speed)*16*(256-reload)).
// - A baud_ctrl bit lets the generator clock mode 0.
// - Control bit 7 is framing_error or mode_sel_hi; only software clears the error.
// - Modes: 0 shift /6, 1 8-bit variable, 2 9-bit /32 or /16, 3 9-bit variable.
// - Reception only while the receive-allow bit is set.
// - Modes 2 and 3 send tx_ninth_bit as the ninth data bit.
// - rx_ninth_bit takes ninth bit in modes 2/3, stop bit in mode 1; rb8_q loads rx_evt.bit9 in mode 1 too, not stop_ok.
// - tx_done_flag set after eighth bit in mode 0, at stop start otherwise.
// - Mode 0 sets rx_done_flag after eighth bit; software clears it.
package uart_amr_pkg;
  localparam int ADDR_W_MIN = 10;
  localparam logic [7:0] IDX_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] IDX_ADDRESS_MASK = 8'hb9;
  localparam logic [7:0] IDX_OWN_ADDRESS = 8'ha9;
  localparam logic [7:0] IDX_BRG_RELOAD = 8'h9a;
  localparam logic [7:0] IDX_BAUD_CTRL = 8'h9b;
  localparam logic [7:0] IDX_TIMER2_CTRL = 8'hc8;
  localparam logic [7:0] IDX_POWER_CTRL = 8'h87;
  localparam logic [7:0] SC_RESET = 8'h00;
  localparam logic [7:0] OWN_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] BRL_RESET = 8'h00;
  localparam logic [4:0] BC_RESET = 5'h00;
  localparam int SC_BIT7 = 7;
  localparam int SC_MODE_LO = 6;
  localparam int SC_MP = 5;
  localparam int SC_REN = 4;
  localparam int SC_TB8 = 3;
  localparam int SC_RB8 = 2;
  localparam int SC_TI = 1;
  localparam int SC_RI = 0;
  localparam int PC_DOUBLER = 7;
  localparam int PC_EBA = 6;
  localparam int T2_RCLK = 5;
  localparam int T2_TX_TIMER2_SELECT = 4;
  localparam int BC_RUN = 4;
  localparam int BC_TXGEN = 3;
  localparam int BC_RXGEN = 2;
  localparam int BC_SPD = 1;
  localparam int BC_M0SRC = 0;
  localparam logic [2:0] DIV6_LAST = 3'h5;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [7:0] CNT_TOP = 8'hff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    MODE_SHIFT = 2'h0,
    MODE_UART8 = 2'h1,
    MODE_UART9_FIXED = 2'h2,
    MODE_UART9_VAR = 2'h3
  } mode_e;
  typedef struct packed {
    logic [7:0] data;
    logic bit9;
    logic stop_ok;
  } rx_evt_s;
endpackage
